// ---- shared/mpc_consts.svh ----
// Purpose: Named levels, times and counts for the modem power control sequencer.
// Assumes: A 125 MHz system clock; times are given in their own unit.
// Notes:   Cycle counts are derived from these figures inside the top module.
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// System clock rate in kilohertz, used to turn times into cycle counts.
`define MPC_CLK_KHZ      125000
`define MPC_US_PER_MS    1000

// Toggle hold times in milliseconds; both sequences wait at least 3 s.
`define MPC_ON_HOLD_MS   3000
`define MPC_OFF_HOLD_MS  3000

// Reset pulse widths: modem in milliseconds, GNSS receiver in microseconds.
`define MPC_MRST_MS      200
`define MPC_GRST_US      1000

// Cycles allowed for the power monitor to settle before it is sampled.
`define MPC_SETTLE_CYC   8

// Pin levels.
`define MPC_SUPPLY_ON    1'b0
`define MPC_SUPPLY_OFF   1'b1
`define MPC_ISO_DRIVE    1'b0
`define MPC_ISO_HIZ      1'b1
`define MPC_VBUS_GND     1'b0
`define MPC_TOGGLE_RUN   1'b0
`define MPC_TOGGLE_ACT   1'b1
`define MPC_RST_RUN      1'b0
`define MPC_RST_ACT      1'b1
`define MPC_SVC_OFF      1'b0
`define MPC_POWER_MONITOR_ON    1'b0
`define MPC_POWER_MONITOR_OFF   1'b1

`endif

// ---- shared/mpc_pkg.sv ----
// Purpose: Types shared by the modem power control sequencer files.
// Assumes: Levels and counts come from mpc_consts.svh.
// Notes:   Pin and status groups travel as packed structs.
package mpc_pkg;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_OFF,
    ST_ON_PREP,
    ST_ON_TOGGLE,
    ST_ON_SETTLE,
    ST_ON,
    ST_OFF_ISOLATE,
    ST_OFF_TOGGLE,
    ST_OFF_SETTLE,
    ST_MODEM_RESET
  } seq_state_t;

  // Ordered preparation steps of the power-on sequence.
  typedef enum logic [2:0] {
    PS_SUPPLY,
    PS_RESET,
    PS_ISOLATE,
    PS_SERVICE,
    PS_GNSS
  } prep_step_t;

  // Control lines toward the plug-in modem.
  typedef struct packed {
    logic supply_en_n;   // Low feeds the modem supply.
    logic isolate;       // High puts the level-shifted outputs in high impedance.
    logic vbus_en;       // High applies 5 V to the modem VBUS input.
    logic toggle;        // On/off toggle line.
    logic modem_reset;   // Modem reset line.
    logic service_sel;   // Service select line.
    logic gnss_reset;    // GNSS receiver reset line.
  } modem_pins_t;

  // Sequence status toward the host logic.
  typedef struct packed {
    logic done;          // One-cycle pulse at the end of each sequence.
    logic power_monitor_result; // Power monitor level sampled at that end.
    logic modem_on;      // Modem confirmed on.
    logic seq_fail;      // Last sequence did not see the expected monitor level.
  } seq_status_t;

endpackage

// ---- verilog/mpc_sync2.sv ----
// Purpose: Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes: The input changes slowly compared with the clock.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
`include "mpc_consts.svh"
module mpc_sync2 (
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta;       // First stage, read only by the second.
  logic next_meta;  // Next value of the first stage.
  logic next_sync;  // Next value of the second stage.

  // Shift the level through both stages.
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  // Register both stages; reset gives the modem-off level.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta   <= `MPC_POWER_MONITOR_OFF;
      sync_o <= `MPC_POWER_MONITOR_OFF;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule // mpc_sync2

// ---- verilog/mpc_interval_timer.sv ----
// Purpose: Down counter that measures one hold or wait interval.
// Assumes: A load value of at least one cycle.
// Notes:   Expired is a level that stays high while the count is zero.
`timescale 1ns/1ps
module mpc_interval_timer #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  // Load strobe and interval length in cycles.
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // Interval over.
  output logic              expired_o
);

  logic [W-1:0] count;       // Cycles left.
  logic [W-1:0] next_count;  // Next value of the count.

  // A load wins over the running count so a new interval starts cleanly.
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  // Register the count.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Expired while nothing is left to count.
  assign expired_o = (count == '0);

endmodule // mpc_interval_timer

// ---- verilog/modem_power_control_sequencer.sv ----
// Purpose: Powers, resets and switches a plug-in cellular modem through its control lines.
// Assumes: 125 MHz core_clk_i; requests come from logic on the same clock.
// Notes:   Long counts are parameters so a simulation can shorten them.
// Notes on behaviour
// - Supply enable low feeds modem, high disables.
// - Isolation low drives outputs, high makes them float.
// - Isolation high whenever the modem is unpowered.
// - VBUS enable low grounds VBUS, high applies 5V.
// - Switch on: toggle high longer than 1 s.
// - Switch off: toggle high longer than 2 s.
// - Toggle stays low outside a pulse.
// - Modem reset low normally, high over 200 ms.
// - Service select low disables, high enables service.
// - GNSS reset low normally, high over 1 ms.
// - Power-on steps in fixed order, toggle 3 s.
// - Release isolation only after monitor reads low.
// - Power-off begins by raising isolation first.
// - Off: toggle 3 s, then expect monitor high.
`timescale 1ns/1ps
`include "mpc_consts.svh"
module modem_power_control_sequencer
  import mpc_pkg::*;
#(
  parameter int unsigned TIMER_W     = 32,
  parameter bit          HAS_SERVICE = 1'b1,
  parameter bit          HAS_GNSS    = 1'b1,
  parameter int unsigned ON_HOLD_CYC  = `MPC_ON_HOLD_MS * `MPC_CLK_KHZ,
  parameter int unsigned OFF_HOLD_CYC = `MPC_OFF_HOLD_MS * `MPC_CLK_KHZ,
  parameter int unsigned MRST_CYC     = `MPC_MRST_MS * `MPC_CLK_KHZ + 1,
  parameter int unsigned GRST_CYC     = `MPC_GRST_US * `MPC_CLK_KHZ / `MPC_US_PER_MS + 1,
  parameter int unsigned SETTLE_CYC   = `MPC_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic  core_clk_i,
  input  wire logic  resetn_i,
  // Requests from host logic, one-cycle strobes or levels.
  input  wire logic  power_on_req_i,
  input  wire logic  power_off_req_i,
  input  wire logic  modem_reset_req_i,
  input  wire logic  gnss_reset_req_i,
  // Levels: service select applied while the modem is on, VBUS enable in every state.
  input  wire logic  service_enable_i,
  input  wire logic  vbus_enable_i,
  // Power monitor pin from the modem.
  input  wire logic  power_monitor_i,
  // Control lines toward the modem.
  output modem_pins_t modem_pins_o,
  // Sequence status.
  output seq_status_t status_o,
  output logic        busy_o
);

  // Reset values: supply disabled, outputs isolated, VBUS grounded, service select off, toggle and reset lines at run.
  localparam modem_pins_t PINS_RESET = '{
    supply_en_n: `MPC_SUPPLY_OFF, isolate: `MPC_ISO_HIZ, vbus_en: `MPC_VBUS_GND,
    toggle: `MPC_TOGGLE_RUN, modem_reset: `MPC_RST_RUN, service_sel: `MPC_SVC_OFF,
    gnss_reset: `MPC_RST_RUN};

  seq_state_t          state;          // Sequencer state.
  seq_state_t          next_state;     // Next sequencer state.
  prep_step_t          step;           // Current power-on preparation step.
  prep_step_t          next_step;      // Next preparation step.
  modem_pins_t         pins;           // Registered control lines.
  modem_pins_t         next_pins;      // Next control lines.
  seq_status_t         status;         // Registered status.
  seq_status_t         next_status;    // Next status.
  logic                seq_load;       // Start a sequence interval.
  logic [TIMER_W-1:0]  seq_value;      // Length of that interval.
  logic                seq_expired;    // Sequence interval over.
  logic                gnss_active;    // GNSS reset pulse in progress.
  logic                next_gnss_active;
  logic                gnss_go;        // Start a GNSS reset pulse.
  logic                gnss_expired;   // GNSS interval over.
  logic                power_monitor_s;       // Synchronised power monitor level.

  // The monitor pin is asynchronous to our clock.
  mpc_sync2 u_power_monitor_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    (power_monitor_i),
    .sync_o     (power_monitor_s)
  );

  // Interval timer for toggle holds, modem reset and settle waits.
  mpc_interval_timer #(.W(TIMER_W)) u_seq_timer (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .load_i     (seq_load),
    .value_i    (seq_value),
    .expired_o  (seq_expired)
  );

  // Separate timer so a GNSS reset can run alongside the sequencer.
  mpc_interval_timer #(.W(TIMER_W)) u_gnss_timer (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .load_i     (gnss_go),
    .value_i    (TIMER_W'(GRST_CYC)),
    .expired_o  (gnss_expired)
  );

  // GNSS reset pulse; only while the modem is on, and ignored if one is running.
  always_comb begin
    gnss_go          = HAS_GNSS && gnss_reset_req_i && (state == ST_ON) && !gnss_active;
    next_gnss_active = gnss_active ? !gnss_expired : gnss_go;
  end

  // Register the GNSS pulse state.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gnss_active <= 1'b0;
    end else begin
      gnss_active <= next_gnss_active;
    end
  end

  // Sequencer next state. vbus_en, gnss_reset and service_sel are set every cycle; other pins only change where a step calls for it.
  always_comb begin
    next_state          = state;
    next_step           = step;
    next_pins           = pins;
    next_status         = status;
    next_status.done    = 1'b0;
    seq_load            = 1'b0;
    seq_value           = '0;
    next_pins.vbus_en   = vbus_enable_i;
    next_pins.gnss_reset = gnss_active ? `MPC_RST_ACT : `MPC_RST_RUN;
    next_pins.service_sel = `MPC_SVC_OFF;
    unique case (state)
      // Modem assumed off; waits for a power-on request.
      ST_OFF: begin
        if (power_on_req_i) begin
          next_state         = ST_ON_PREP;
          next_step          = PS_SUPPLY;
          next_status.seq_fail = 1'b0;
        end
      end
      // One preparation step per cycle so the lines move in the set order.
      ST_ON_PREP: begin
        unique case (step)
          PS_SUPPLY: begin
            next_pins.supply_en_n = `MPC_SUPPLY_ON;
            next_step = PS_RESET;
          end
          PS_RESET: begin
            next_pins.modem_reset = `MPC_RST_RUN;
            next_step = PS_ISOLATE;
          end
          PS_ISOLATE: begin
            next_pins.isolate = `MPC_ISO_HIZ;
            next_step = PS_SERVICE;
          end
          PS_SERVICE: begin
            next_pins.service_sel = `MPC_SVC_OFF;
            next_step = PS_GNSS;
          end
          PS_GNSS: begin
            // GNSS reset is already low: pulses start only in the on state.
            next_pins.toggle = `MPC_TOGGLE_ACT;
            seq_load   = 1'b1;
            seq_value  = TIMER_W'(ON_HOLD_CYC);
            next_state = ST_ON_TOGGLE;
          end
        endcase
      end
      // Hold the toggle for the full power-on interval.
      ST_ON_TOGGLE: begin
        if (seq_expired) begin
          next_pins.toggle = `MPC_TOGGLE_RUN;
          seq_load   = 1'b1;
          seq_value  = TIMER_W'(SETTLE_CYC);
          next_state = ST_ON_SETTLE;
        end
      end
      // Sample the monitor; only a low level releases the outputs.
      ST_ON_SETTLE: begin
        if (seq_expired) begin
          next_status.done          = 1'b1;
          next_status.power_monitor_result = power_monitor_s;
          if (power_monitor_s == `MPC_POWER_MONITOR_ON) begin
            next_pins.isolate    = `MPC_ISO_DRIVE;
            next_status.modem_on = 1'b1;
            next_state           = ST_ON;
          end else begin
            // Modem did not come up: keep outputs floating.
            next_status.seq_fail = 1'b1;
            next_state           = ST_OFF;
          end
        end
      end
      // Modem running; the command UART is usable from here.
      ST_ON: begin
        next_pins.service_sel = HAS_SERVICE ? service_enable_i : `MPC_SVC_OFF;
        if (power_off_req_i) begin
          next_pins.isolate    = `MPC_ISO_HIZ;
          next_pins.service_sel = `MPC_SVC_OFF;
          next_status.seq_fail = 1'b0;
          next_state           = ST_OFF_ISOLATE;
        end else if (modem_reset_req_i) begin
          next_pins.modem_reset = `MPC_RST_ACT;
          seq_load   = 1'b1;
          seq_value  = TIMER_W'(MRST_CYC);
          next_state = ST_MODEM_RESET;
        end
      end
      // Isolation is already high; now start the off pulse.
      ST_OFF_ISOLATE: begin
        next_pins.toggle = `MPC_TOGGLE_ACT;
        seq_load   = 1'b1;
        seq_value  = TIMER_W'(OFF_HOLD_CYC);
        next_state = ST_OFF_TOGGLE;
      end
      // Hold the toggle for the full power-off interval.
      ST_OFF_TOGGLE: begin
        if (seq_expired) begin
          next_pins.toggle = `MPC_TOGGLE_RUN;
          seq_load   = 1'b1;
          seq_value  = TIMER_W'(SETTLE_CYC);
          next_state = ST_OFF_SETTLE;
        end
      end
      // A high monitor level confirms the modem is off.
      ST_OFF_SETTLE: begin
        if (seq_expired) begin
          next_status.done          = 1'b1;
          next_status.power_monitor_result = power_monitor_s;
          if (power_monitor_s == `MPC_POWER_MONITOR_OFF) begin
            next_status.modem_on = 1'b0;
            next_state           = ST_OFF;
          end else begin
            // Still on: give the outputs back so the modem stays reachable.
            next_status.seq_fail = 1'b1;
            next_pins.isolate    = `MPC_ISO_DRIVE;
            next_state           = ST_ON;
          end
        end
      end
      // Hold the modem in reset, then return to running.
      ST_MODEM_RESET: begin
        if (seq_expired) begin
          next_pins.modem_reset     = `MPC_RST_RUN;
          next_status.done          = 1'b1;
          next_status.power_monitor_result = power_monitor_s;
          next_state                = ST_ON;
        end
      end
    endcase
  end

  // Register the sequencer state, pins and status.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state  <= ST_OFF;
      step   <= PS_SUPPLY;
      pins   <= PINS_RESET;
      status <= '0;
    end else begin
      state  <= next_state;
      step   <= next_step;
      pins   <= next_pins;
      status <= next_status;
    end
  end

  // Outputs come straight from flip-flops; busy is a handshake term.
  assign modem_pins_o = pins;
  assign status_o     = status;
  assign busy_o       = (state != ST_OFF) && (state != ST_ON);

  // Helper counters of how long each pulse line has been high.
  logic [31:0] tog_cnt;
  logic [31:0] mrst_cnt;
  logic [31:0] grst_cnt;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_cnt  <= 32'h0000_0000;
      mrst_cnt <= 32'h0000_0000;
      grst_cnt <= 32'h0000_0000;
    end else begin
      tog_cnt  <= pins.toggle ? tog_cnt + 32'h0000_0001 : 32'h0000_0000;
      mrst_cnt <= pins.modem_reset ? mrst_cnt + 32'h0000_0001 : 32'h0000_0000;
      grst_cnt <= pins.gnss_reset ? grst_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // The on pulse lasts the whole power-on hold.
  property p_on_hold;
    $fell(pins.toggle) && state == ST_ON_SETTLE |-> tog_cnt >= ON_HOLD_CYC;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("on toggle too short");

  // The off pulse lasts the whole power-off hold.
  property p_off_hold;
    $fell(pins.toggle) && state == ST_OFF_SETTLE |-> tog_cnt >= OFF_HOLD_CYC;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off toggle too short");

  // Unpowered modem always sees floating outputs.
  property p_iso_unpowered;
    pins.supply_en_n == `MPC_SUPPLY_OFF |-> pins.isolate == `MPC_ISO_HIZ;
  endproperty
  a_iso_unpowered: assert property (p_iso_unpowered) else $error("isolation low unpowered");

  // Modem reset pulse is longer than its minimum.
  property p_mrst_width;
    $fell(pins.modem_reset) |-> mrst_cnt >= MRST_CYC;
  endproperty
  a_mrst_width: assert property (p_mrst_width) else $error("modem reset too short");

  // GNSS reset pulse is longer than its minimum.
  property p_grst_width;
    $fell(pins.gnss_reset) |-> grst_cnt >= GRST_CYC;
  endproperty
  a_grst_width: assert property (p_grst_width) else $error("gnss reset too short");

  // Isolation drops only after the monitor was seen low.
  property p_iso_release;
    $fell(pins.isolate) |-> $past(power_monitor_s) == `MPC_POWER_MONITOR_ON && status.done;
  endproperty
  a_iso_release: assert property (p_iso_release) else $error("isolation released early");

  // Power-off raises isolation before the toggle moves.
  property p_off_iso_first;
    state == ST_ON && power_off_req_i |=> pins.isolate && !pins.toggle ##1 pins.toggle;
  endproperty
  a_off_iso_first: assert property (p_off_iso_first) else $error("off order wrong");

  // Done is a single-cycle pulse.
  property p_done_pulse;
    status.done |=> !status.done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  // Toggle rises only after supply, reset and isolation are set.
  property p_toggle_ready;
    $rose(pins.toggle) |-> !pins.supply_en_n && !pins.modem_reset && pins.isolate;
  endproperty
  a_toggle_ready: assert property (p_toggle_ready) else $error("toggle before prep");

  // Service select is only high while the modem runs.
  property p_service_on;
    pins.service_sel |-> $past(state) == ST_ON;
  endproperty
  a_service_on: assert property (p_service_on) else $error("service outside on state");

  // Main scenarios.
  c_power_on: cover property (state == ST_ON_SETTLE && seq_expired && !power_monitor_s);
  c_power_off: cover property (state == ST_OFF_SETTLE && seq_expired && power_monitor_s);
  c_modem_reset: cover property ($fell(pins.modem_reset));
  c_gnss_reset: cover property ($fell(pins.gnss_reset));

endmodule // modem_power_control_sequencer

// ---- bench/modem_model.sv ----
// Purpose: Behavioural plug-in modem that answers on/off toggle pulses on its monitor pin.
// Assumes: Toggle hold is counted in core clock cycles, scaled down like the sequencer.
// Notes:   Stubborn mode ignores every toggle, so a failed sequence can be shown.
`timescale 1ns/1ps
module modem_model
  import mpc_pkg::*;
#(
  parameter int unsigned HOLD_MIN = 10
) (
  // Clock.
  input  wire logic        core_clk_i,
  // Lines from the sequencer and test control.
  input  wire modem_pins_t pins_i,
  input  wire logic        stubborn_i,
  // Power monitor toward the sequencer.
  output logic             power_monitor_o
);
  int   hold  = 0;     // Cycles the toggle has been high so far.
  // The modem wakes up in its off state after board power-up.
  logic is_on = 1'b0;

  // A long enough toggle pulse flips the state when it ends; no supply forces it off.
  always @(posedge core_clk_i) begin
    if (pins_i.supply_en_n) begin
      is_on <= 1'b0;
      hold  <= 0;
    end else if (pins_i.toggle) begin
      hold <= hold + 1;
    end else begin
      // A short pulse is ignored, as the real part would ignore it.
      if (hold >= HOLD_MIN && !stubborn_i) begin
        is_on <= !is_on;
      end
      hold <= 0;
    end
  end

  // The monitor reads low while on and high while off.
  assign power_monitor_o = is_on ? 1'b0 : 1'b1;
endmodule  // modem_model

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the modem power control sequencer.
// Assumes: Hold and pulse counts are shortened through the design's parameters.
// Notes:   Each scenario drives the block and judges the outcome before it returns.
`timescale 1ns/1ps
module tb_top
  import mpc_pkg::*;
;
  localparam int HOLD = 20;  // Shortened toggle hold in cycles.
  localparam int MRST = 10;  // Shortened modem reset width.
  localparam int GRST = 5;   // Shortened receiver reset width.

  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        on_req     = 1'b0;
  logic        off_req    = 1'b0;
  logic        mrst_req   = 1'b0;
  logic        grst_req   = 1'b0;
  logic        svc_en     = 1'b0;
  logic        vbus_en    = 1'b0;
  logic        stubborn   = 1'b0;
  logic        power_monitor;
  modem_pins_t pins;
  seq_status_t status;
  logic        busy;
  int          n_errors   = 0;
  int          compares   = 0;

  modem_power_control_sequencer #(.ON_HOLD_CYC(HOLD), .OFF_HOLD_CYC(HOLD), .MRST_CYC(MRST),
    .GRST_CYC(GRST), .SETTLE_CYC(8)) uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .power_on_req_i(on_req), .power_off_req_i(off_req), .modem_reset_req_i(mrst_req),
    .gnss_reset_req_i(grst_req), .service_enable_i(svc_en), .vbus_enable_i(vbus_en),
    .power_monitor_i(power_monitor), .modem_pins_o(pins), .status_o(status), .busy_o(busy));

  modem_model #(.HOLD_MIN(10)) modem (.core_clk_i(core_clk_i), .pins_i(pins),
    .stubborn_i(stubborn), .power_monitor_o(power_monitor));

  // The clock runs at 125 MHz.
  always #4 core_clk_i = ~core_clk_i;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  // Inputs always change one nanosecond after the rising edge.
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic strobe(ref logic r);
    r = 1'b1;
    tick();
    r = 1'b0;
  endtask

  // Waits for one line to rise, keeps the pins seen then, and counts its high cycles.
  task automatic pulse(input int b, output int len, output modem_pins_t f);
    int guard;
    guard = 0;
    len = 0;
    while (pins[b] !== 1'b1 && guard < 200) begin
      tick();
      guard++;
    end
    f = pins;
    while (pins[b] === 1'b1 && len < 200) begin
      len++;
      tick();
    end
  endtask

  // The done pulse lasts one cycle, so every cycle is looked at.
  task automatic wait_done();
    int guard;
    guard = 0;
    while (status.done !== 1'b1 && guard < 100) begin
      tick();
      guard++;
    end
  endtask

  task automatic t_reset();
    check({1'b0, pins}, 8'h60);
    check({3'h0, status, busy}, 8'h00);
  endtask

  task automatic t_power_on(input logic stuck);
    int          len;
    modem_pins_t f;
    stubborn = stuck;
    strobe(on_req);
    check(8'(busy), 8'h01);
    pulse(3, len, f);
    check(8'(len), 8'(HOLD + 1));
    check(8'({f.supply_en_n, f.modem_reset, f.isolate, f.service_sel, f.gnss_reset}), 8'h04);
    wait_done();
    check(8'(status), stuck ? 8'h0d : 8'h0a);
    check(8'({pins.isolate, pins.supply_en_n}), stuck ? 8'h02 : 8'h00);
    tick();
    check(8'({status.done, pins.toggle}), 8'h00);
  endtask

  task automatic t_levels();
    svc_en = 1'b1;
    vbus_en = 1'b1;
    tick();
    tick();
    check(8'({pins.service_sel, pins.vbus_en}), 8'h03);
    svc_en = 1'b0;
    vbus_en = 1'b0;
    tick();
    tick();
    check(8'({pins.service_sel, pins.vbus_en}), 8'h00);
  endtask

  task automatic t_resets();
    int          len;
    modem_pins_t f;
    strobe(mrst_req);
    pulse(2, len, f);
    check(8'(len), 8'(MRST + 1));
    check(8'({status.done, pins.isolate}), 8'h02);
    strobe(grst_req);
    pulse(0, len, f);
    check(8'(len), 8'(GRST + 1));
  endtask

  task automatic t_power_off(input logic stuck);
    int          len;
    modem_pins_t f;
    stubborn = stuck;
    strobe(off_req);
    check(8'({pins.isolate, pins.toggle}), 8'h02);
    pulse(3, len, f);
    check(8'(len), 8'(HOLD + 1));
    wait_done();
    check(8'(status), stuck ? 8'h0b : 8'h0c);
    check(8'(pins.isolate), stuck ? 8'h00 : 8'h01);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The whole run takes well under a thousand cycles.
  initial begin
    #(3000 * 8);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge core_clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_power_on(1'b1);
    t_power_on(1'b0);
    t_levels();
    t_resets();
    t_power_off(1'b1);
    t_power_off(1'b0);
    print_verdict();
  end
endmodule  // tb_top
